// ### lota_defs.svh
// lota_defs.svh: constants for the logic-op and port-direction datapath slice
// assumes: included by bare name from the package and the datapath modules
`ifndef LOTA_DEFS_SVH
`define LOTA_DEFS_SVH

// ----------------------------------------------------------------------------
// widths and ranges
// ----------------------------------------------------------------------------
`define LOTA_DATA_W      8            // accumulator and operand width
`define LOTA_FADDR_W     5            // file register address width
`define LOTA_FILE_DEPTH  32           // file registers 0 to 31
`define LOTA_LIT_MAX     8'hff        // largest literal, 255

// ----------------------------------------------------------------------------
// destination bit and direction register selectors
// ----------------------------------------------------------------------------
`define LOTA_DEST_ACC    1'h0         // result to the accumulator
`define LOTA_DEST_FILE   1'h1         // result back to the file register
`define LOTA_DIR_SEL_A   5'h06        // first port direction register
`define LOTA_DIR_SEL_B   5'h07        // second port direction register

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LOTA_ACC_RST     8'h00        // accumulator after reset
`define LOTA_DIR_RST     8'hff        // direction registers: all inputs
`define LOTA_ZERO_RST    1'h0         // zero flag after reset

`endif

// ### lota_pkg.sv
// lota_pkg.sv: types shared by the datapath slice
// assumes: lota_defs.svh is on the include path
package lota_pkg;
`include "lota_defs.svh"

   // operation codes given by the decoder
   typedef enum logic [2:0] {
      LOTA_OP_NONE        = 3'h0,     // idle cycle, nothing changes
      LOTA_OP_OR_LIT      = 3'h1,     // or_literal_into_acc
      LOTA_OP_XOR_LIT     = 3'h2,     // xor_literal_into_acc
      LOTA_OP_XOR_FILE    = 3'h3,     // xor_acc_with_file
      LOTA_OP_LOAD_DIR    = 3'h4      // load_port_direction
   } lota_op_t;

   // one decoded instruction
   typedef struct packed {
      lota_op_t                   op;     // operation
      logic [`LOTA_DATA_W-1:0]    lit;    // literal operand
      logic [`LOTA_FADDR_W-1:0]   faddr;  // file address or direction selector
      logic                       dest;   // destination bit
   } lota_instr_t;

   // status flag outputs
   typedef struct packed {
      logic zero;                     // zero flag
      logic zero_we;                  // zero flag updated this cycle
   } lota_flags_t;
endpackage

// ### lota_file_ram.sv
// lota_file_ram.sv: 32 x 8 file register memory with registered read data
// assumes: one clock, synchronous active-low reset, one write port
`include "lota_defs.svh"
module lota_file_ram
   import lota_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [`LOTA_FADDR_W-1:0]  raddr,
   output logic      [`LOTA_DATA_W-1:0]   rdata,
   input  wire logic                      we,
   input  wire logic [`LOTA_FADDR_W-1:0]  waddr,
   input  wire logic [`LOTA_DATA_W-1:0]   wdata
);
   // ---------------------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------------------
   logic [`LOTA_DATA_W-1:0] mem_q [`LOTA_FILE_DEPTH];   // file registers
   logic [`LOTA_DATA_W-1:0] rdata_q;                    // registered read data

   // write port, contents cleared on reset so the first xor reads a known value
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `LOTA_FILE_DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // registered read, old data on a same-address write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= mem_q[raddr];
      end
   end

   assign rdata = rdata_q;
endmodule // lota_file_ram

// ### lota_core.sv
// lota_core.sv: logic-op and port-direction datapath slice of an 8-bit core
// assumes: the decoder holds each instruction stable for its cycle and
// drives the file read address one cycle ahead (faddr_next)
//
// Contract
// - or literal into accumulator, update zero
// - xor literal into accumulator, update zero
// - xor accumulator with file register, update zero
// - destination bit picks accumulator or file
// - load direction register 6/7, flags kept
`include "lota_defs.svh"
module lota_core
   import lota_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire lota_instr_t               instr,
   input  wire logic [`LOTA_FADDR_W-1:0]  faddr_next,
   output logic      [`LOTA_DATA_W-1:0]   acc,
   output lota_flags_t                    flags,
   output logic      [`LOTA_DATA_W-1:0]   dir_a,
   output logic      [`LOTA_DATA_W-1:0]   dir_b,
   output logic      [`LOTA_DATA_W-1:0]   file_rdata
);
   // ---------------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------------
   logic [`LOTA_DATA_W-1:0] acc_q, acc_d;      // accumulator
   logic                    zero_q, zero_d;    // zero flag
   logic                    zwe_q, zwe_d;      // zero flag update strobe
   logic [`LOTA_DATA_W-1:0] dir_a_q, dir_a_d;  // direction register at 6
   logic [`LOTA_DATA_W-1:0] dir_b_q, dir_b_d;  // direction register at 7
   logic [`LOTA_DATA_W-1:0] fdata;             // addressed file register

   // zero test, used for every flag-affecting result
   function automatic logic is_zero(input logic [`LOTA_DATA_W-1:0] v);
      return (v == 8'h00);
   endfunction

   // ---------------------------------------------------------------------------
   // decode and results
   // ---------------------------------------------------------------------------
   wire is_or_lit   = (instr.op == LOTA_OP_OR_LIT);
   wire is_xor_lit  = (instr.op == LOTA_OP_XOR_LIT);
   wire is_xor_file = (instr.op == LOTA_OP_XOR_FILE);
   wire is_load_dir = (instr.op == LOTA_OP_LOAD_DIR);

   wire [`LOTA_DATA_W-1:0] or_lit_res   = acc_q | instr.lit;
   wire [`LOTA_DATA_W-1:0] xor_lit_res  = acc_q ^ instr.lit;
   wire [`LOTA_DATA_W-1:0] xor_file_res = acc_q ^ fdata;

   // result that drives the zero flag
   wire [`LOTA_DATA_W-1:0] alu_res = is_or_lit  ? or_lit_res  :
                                     is_xor_lit ? xor_lit_res : xor_file_res;
   wire affects_zero = is_or_lit | is_xor_lit | is_xor_file;

   // destination routing of results and direction selector decode
   wire to_file = is_xor_file & (instr.dest == `LOTA_DEST_FILE);
   wire to_acc  = is_or_lit | is_xor_lit |
                  (is_xor_file & (instr.dest == `LOTA_DEST_ACC));
   wire load_a  = is_load_dir & (instr.faddr == `LOTA_DIR_SEL_A);
   wire load_b  = is_load_dir & (instr.faddr == `LOTA_DIR_SEL_B);

   // ---------------------------------------------------------------------------
   // next-state
   // ---------------------------------------------------------------------------
   assign acc_d   = to_acc ? alu_res : acc_q;
   assign zero_d  = affects_zero ? is_zero(alu_res) : zero_q;
   assign zwe_d   = affects_zero;
   assign dir_a_d = load_a ? acc_q : dir_a_q;
   assign dir_b_d = load_b ? acc_q : dir_b_q;

   // register update
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_q   <= `LOTA_ACC_RST;
         zero_q  <= `LOTA_ZERO_RST;
         zwe_q   <= 1'h0;
         dir_a_q <= `LOTA_DIR_RST;
         dir_b_q <= `LOTA_DIR_RST;
      end else begin
         acc_q   <= acc_d;
         zero_q  <= zero_d;
         zwe_q   <= zwe_d;
         dir_a_q <= dir_a_d;
         dir_b_q <= dir_b_d;
      end
   end

   // ---------------------------------------------------------------------------
   // file register memory
   // ---------------------------------------------------------------------------
   lota_file_ram u_file (
      .clk   (clk),
      .rst_n (rst_n),
      .raddr (faddr_next),
      .rdata (fdata),
      .we    (to_file),
      .waddr (instr.faddr),
      .wdata (xor_file_res)
   );

   assign acc          = acc_q;
   assign flags.zero   = zero_q;
   assign flags.zero_we = zwe_q;
   assign dir_a        = dir_a_q;
   assign dir_b        = dir_b_q;
   assign file_rdata   = fdata;

   // ---------------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------------
   // named steps, each used by a single property
   sequence s_flag_op;
      affects_zero;
   endsequence

   sequence s_file_dest;
      is_xor_file && (instr.dest == `LOTA_DEST_FILE);
   endsequence

   sequence s_bad_selector;
      is_load_dir && !load_a && !load_b;
   endsequence

   sequence s_idle;
      (instr.op == LOTA_OP_NONE);
   endsequence

   // or with a literal ors into the accumulator
   property p_or_lit;
      @(posedge clk) disable iff (!rst_n)
      is_or_lit |=> acc_q == ($past(acc_q) | $past(instr.lit));
   endproperty
   a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

   // xor with a literal xors into the accumulator
   property p_xor_lit;
      @(posedge clk) disable iff (!rst_n)
      is_xor_lit |=> acc_q == ($past(acc_q) ^ $past(instr.lit));
   endproperty
   a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

   // file xor with destination 0 lands in the accumulator
   property p_xor_file_acc;
      @(posedge clk) disable iff (!rst_n)
      (is_xor_file && instr.dest == 1'h0) |=> acc_q == ($past(acc_q) ^ $past(fdata));
   endproperty
   a_xor_file_acc: assert property (p_xor_file_acc) else $error("xor file to acc wrong");

   // file xor with destination 1 leaves the accumulator alone
   property p_file_keeps_acc;
      @(posedge clk) disable iff (!rst_n)
      (is_xor_file && instr.dest == 1'h1) |=> $stable(acc_q);
   endproperty
   a_file_keeps_acc: assert property (p_file_keeps_acc) else $error("acc changed");

   // file xor written back still sets the zero flag from its result
   property p_file_zero;
      @(posedge clk) disable iff (!rst_n)
      s_file_dest |=> zwe_q && (zero_q == $past(is_zero(xor_file_res)));
   endproperty
   a_file_zero: assert property (p_file_zero) else $error("file xor zero wrong");

   // selector 6 loads the first direction register
   property p_load_dir;
      @(posedge clk) disable iff (!rst_n)
      load_a |=> dir_a_q == $past(acc_q) && $stable(zero_q) && $stable(dir_b_q);
   endproperty
   a_load_dir: assert property (p_load_dir) else $error("direction load wrong");

   // selector 7 loads the second direction register
   property p_load_dir_b;
      @(posedge clk) disable iff (!rst_n)
      load_b |=> dir_b_q == $past(acc_q) && $stable(zero_q) && $stable(dir_a_q);
   endproperty
   a_load_dir_b: assert property (p_load_dir_b) else $error("second direction load wrong");

   // any other selector leaves both direction registers untouched
   property p_load_refused;
      @(posedge clk) disable iff (!rst_n)
      s_bad_selector |=> $stable(dir_a_q) && $stable(dir_b_q);
   endproperty
   a_load_refused: assert property (p_load_refused) else $error("bad selector loaded");

   // a direction load touches neither accumulator nor flags
   property p_load_keeps_acc;
      @(posedge clk) disable iff (!rst_n)
      is_load_dir |=> $stable(acc_q) && !zwe_q;
   endproperty
   a_load_keeps_acc: assert property (p_load_keeps_acc) else $error("load changed state");

   // zero flag follows the accumulator after an accumulator result
   property p_zero_flag;
      @(posedge clk) disable iff (!rst_n)
      zwe_q |-> zero_q == (acc_q == 8'h00) || $past(to_file);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   // zero flag is the zero test of the flag-affecting result
   property p_zero_value;
      @(posedge clk) disable iff (!rst_n)
      s_flag_op |=> zwe_q && (zero_q == $past(is_zero(alu_res)));
   endproperty
   a_zero_value: assert property (p_zero_value) else $error("zero value wrong");

   // an idle cycle changes no visible state
   property p_idle_hold;
      @(posedge clk) disable iff (!rst_n)
      s_idle |=> $stable(acc_q) && $stable(dir_a_q) && $stable(dir_b_q) && !zwe_q;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle changed state");

   // zero flag holds on ops that do not affect it
   property p_zero_hold;
      @(posedge clk) disable iff (!rst_n)
      !affects_zero |=> $stable(zero_q);
   endproperty
   a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved");
endmodule // lota_core

// ### lota_dec_model.sv
// lota_dec_model.sv: decoder-side model feeding the datapath slice
// assumes: one clock; inputs change at the falling edge only
`include "lota_defs.svh"
module lota_dec_model
   import lota_pkg::*;
(
   input  wire logic                     clk,
   output lota_instr_t                   instr,
   output logic [`LOTA_FADDR_W-1:0]      faddr_next
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle op at time zero
   initial begin
      instr      = '0;
      faddr_next = '0;
   end
   // one instruction per cycle, read address for the following cycle
   task automatic step(input lota_op_t op, input logic [7:0] lit,
                       input logic [4:0] fa, input logic d, input logic [4:0] nxt);
      @(negedge clk);
      instr      <= '{op, lit, fa, d};
      faddr_next <= nxt;
   endtask
endmodule // lota_dec_model

// ### logic_ops_and_tristate_load_tb.sv
// logic_ops_and_tristate_load_tb.sv: self-checking bench of lota_core
// assumes: lota_pkg compiled first, lota_dec_model drives the instruction port
`include "lota_defs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module logic_ops_and_tristate_load_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lota_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   int   errors = 0;
   int   cmp_count = 0;
   lota_instr_t instr;
   logic [4:0]  faddr_next;
   always #5 clk = ~clk;
   lota_dec_model dec (.clk(clk), .instr(instr), .faddr_next(faddr_next));
   lota_core dut (.clk(clk), .rst_n(rst_n), .instr(instr), .faddr_next(faddr_next),
      .acc(), .flags(), .dir_a(), .dir_b(), .file_rdata());
   // issue one op, then idle; outputs settle by the idle cycle's falling edge
   task automatic do_op(input lota_op_t op, input logic [7:0] lit, input logic [4:0] fa,
                        input logic d);
      dec.step(op, lit, fa, d, fa);
      dec.step(LOTA_OP_NONE, 8'h00, 5'h00, 1'b0, fa);
   endtask
   task automatic t_reset;
      `CHK("acc", 8'h00, dut.acc)
      `CHK("zero_we", 1'h0, dut.flags.zero_we)
      `CHK("dir_a", 8'hff, dut.dir_a)
      `CHK("dir_b", 8'hff, dut.dir_b)
   endtask
   task automatic t_or_lit;
      do_op(LOTA_OP_OR_LIT, 8'h00, 5'h00, 1'b0);
      `CHK("zero", 1'h1, dut.flags.zero)
      `CHK("zero_we", 1'h1, dut.flags.zero_we)
      dec.step(LOTA_OP_NONE, 8'h00, 5'h00, 1'b0, 5'h00);
      `CHK("zero_we", 1'h0, dut.flags.zero_we)
      do_op(LOTA_OP_OR_LIT, 8'ha5, 5'h00, 1'b0);
      `CHK("acc", 8'ha5, dut.acc)
      `CHK("zero", 1'h0, dut.flags.zero)
      do_op(LOTA_OP_OR_LIT, 8'hff, 5'h00, 1'b0);
      `CHK("acc", 8'hff, dut.acc)
   endtask
   task automatic t_xor_lit;
      do_op(LOTA_OP_XOR_LIT, 8'hff, 5'h00, 1'b0);
      `CHK("acc", 8'h00, dut.acc)
      `CHK("zero", 1'h1, dut.flags.zero)
      do_op(LOTA_OP_XOR_LIT, 8'h3c, 5'h00, 1'b0);
      `CHK("acc", 8'h3c, dut.acc)
      `CHK("zero", 1'h0, dut.flags.zero)
   endtask
   task automatic t_load_dir;
      do_op(LOTA_OP_LOAD_DIR, 8'h00, 5'h06, 1'b0);
      `CHK("dir_a", 8'h3c, dut.dir_a)
      `CHK("dir_b", 8'hff, dut.dir_b)
      `CHK("zero_we", 1'h0, dut.flags.zero_we)
      do_op(LOTA_OP_XOR_LIT, 8'h3c, 5'h00, 1'b0);
      do_op(LOTA_OP_LOAD_DIR, 8'h00, 5'h07, 1'b0);
      `CHK("dir_b", 8'h00, dut.dir_b)
      `CHK("zero", 1'h1, dut.flags.zero)
      do_op(LOTA_OP_XOR_LIT, 8'h5a, 5'h00, 1'b0);
      do_op(LOTA_OP_LOAD_DIR, 8'h00, 5'h05, 1'b0);
      `CHK("dir_a", 8'h3c, dut.dir_a)
      `CHK("dir_b", 8'h00, dut.dir_b)
   endtask
   // two ops on consecutive edges: 5a|81=db, then db^db=00
   task automatic t_back_to_back;
      dec.step(LOTA_OP_OR_LIT, 8'h81, 5'h00, 1'b0, 5'h00);
      do_op(LOTA_OP_XOR_LIT, 8'hdb, 5'h00, 1'b0);
      `CHK("acc", 8'h00, dut.acc)
      `CHK("zero", 1'h1, dut.flags.zero)
   endtask
   // file is cleared by reset; write a5 back, then xor it into the accumulator
   task automatic t_xor_file;
      do_op(LOTA_OP_OR_LIT, 8'ha5, 5'h1f, 1'b0);
      `CHK("file reset", 8'h00, dut.file_rdata)
      do_op(LOTA_OP_XOR_FILE, 8'h00, 5'h1f, 1'b1);
      `CHK("acc", 8'ha5, dut.acc)
      `CHK("zero", 1'h0, dut.flags.zero)
      dec.step(LOTA_OP_NONE, 8'h00, 5'h00, 1'b0, 5'h1f);
      `CHK("file", 8'ha5, dut.file_rdata)
      do_op(LOTA_OP_XOR_FILE, 8'h00, 5'h1f, 1'b0);
      `CHK("acc", 8'h00, dut.acc)
      `CHK("zero", 1'h1, dut.flags.zero)
   endtask
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog against a hung sequence
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      $display("[FAIL] watchdog expired");
      report_and_stop();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_or_lit();
      t_xor_lit();
      t_load_dir();
      t_back_to_back();
      t_xor_file();
      report_and_stop();
   end
endmodule // logic_ops_and_tristate_load_tb
